// ===== can_wake_pkg.sv
/*
 * shared constants, encodings and carriers for the transceiver mode and
 * wake block. assumes a 50 MHz ref_clk; timing figures are in ns and the
 * cycle counts are derived from them here.
 */
package can_wake_pkg;

    // clock rate
    localparam int CLK_MHZ = 50;

    // timing figures in ns (plain defaults, tune to the real part)
    localparam int WAKE_MIN_NS = 500;
    localparam int WAKE_MAX_NS = 1800;
    localparam int EN_DELAY_NS = 20000;

    // least times round up, longest times round down
    localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_MAX_CYC = (WAKE_MAX_NS * CLK_MHZ) / 1000;
    localparam int EN_DELAY_CYC = (EN_DELAY_NS * CLK_MHZ + 999) / 1000;

    // width of the phase and enable counters
    localparam int CNT_W = 12;

    // bus levels as seen on the digital pins
    localparam logic BUS_DOMINANT = 1'h0;
    localparam logic BUS_RECESSIVE = 1'h1;

    // transceiver mode field codes
    typedef enum logic [1:0] {
        XM_OFF = 2'h0,
        XM_WAKE = 2'h1,
        XM_RXONLY = 2'h2,
        XM_NORMAL = 2'h3
    } xcvr_mode_e;

    localparam xcvr_mode_e RESET_MODE = XM_OFF;

    // device operating modes as reported by the mode controller
    typedef enum logic [2:0] {
        DM_NORMAL = 3'h0,
        DM_STOP = 3'h1,
        DM_SLEEP = 3'h2,
        DM_RESTART = 3'h3,
        DM_FAILSAFE = 3'h4
    } dev_mode_e;

    // one-cycle mode write from the serial interface decoder
    typedef struct packed {
        logic valid;
        xcvr_mode_e mode;
    } mode_cmd_s;

    // record of one bus wake-up
    typedef struct packed {
        dev_mode_e dev_mode;
        logic int_raised;
        logic restart_raised;
    } wake_rec_s;

endpackage

// ===== wake_event_buffer.sv
/*
 * two-entry buffer with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module wake_event_buffer #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic v0;
        logic v1;
    } buf_state_s;

    buf_state_s s_reg;
    buf_state_s s_next;

    // full only when the second slot is taken
    assign in_ready = !s_reg.v1;
    assign out_valid = s_reg.v0;
    assign out_data = s_reg.d0;

    always_comb begin
        s_next = s_reg;
        if (s_reg.v0 && out_ready) begin
            s_next.d0 = s_reg.d1;
            s_next.v0 = s_reg.v1;
            s_next.v1 = 1'b0;
        end
        // push uses the pre-pop ready so a full buffer never overwrites
        if (in_valid && !s_reg.v1) begin
            if (!s_next.v0) begin
                s_next.d0 = in_data;
                s_next.v0 = 1'b1;
            end else begin
                s_next.d1 = in_data;
                s_next.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

// ===== can_transceiver_mode_wake.sv
/*
 * transceiver mode control, tx enable delay and bus wake pattern detection.
 * assumes the mode command and device mode come from logic on ref_clk;
 * bus_tx_input and bus_rx_diff are pins and are synchronised here.
 */
`timescale 1ns/1ps
module can_transceiver_mode_wake #(
    parameter int WAKE_MIN = can_wake_pkg::WAKE_MIN_CYC,
    parameter int WAKE_MAX = can_wake_pkg::WAKE_MAX_CYC,
    parameter int EN_DELAY = can_wake_pkg::EN_DELAY_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // mode control
    input can_wake_pkg::mode_cmd_s mode_cmd,
    input can_wake_pkg::dev_mode_e dev_mode,
    output can_wake_pkg::xcvr_mode_e mode_status,
    output logic restart_req,
    output logic interrupt_out_n,
    // controller and bus side pins
    input wire logic bus_tx_input,
    input wire logic bus_rx_diff,
    output logic bus_rx_output,
    output logic bus_driver_en,
    output logic bus_drive_dominant,
    // wake records toward the status logic
    output logic wake_valid,
    input wire logic wake_ready,
    output can_wake_pkg::wake_rec_s wake_rec
);

    localparam int CW = can_wake_pkg::CNT_W;
    localparam logic [CW-1:0] WMIN = CW'(WAKE_MIN);
    localparam logic [CW-1:0] WMAX = CW'(WAKE_MAX);
    localparam logic [CW-1:0] ENDLY = CW'(EN_DELAY);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    typedef enum {
        W_HOLD,
        W_IDLE,
        W_DOM1,
        W_REC,
        W_DOM2
    } wake_state_e;

    typedef struct packed {
        logic tx_s1;
        logic tx_s2;
        logic rx_s1;
        logic rx_s2;
        can_wake_pkg::dev_mode_e dev_prev;
        can_wake_pkg::xcvr_mode_e mode;
        wake_state_e wst;
        logic [CW-1:0] wcnt;
        logic armed;
        logic woken;
        logic int_low;
        logic [CW-1:0] en_cnt;
        logic tx_ok;
        logic drv_en;
        logic drv_dom;
        logic rx_out;
        logic int_n;
        logic restart;
        logic pend_v;
        can_wake_pkg::wake_rec_s pend;
    } top_state_s;

    localparam top_state_s RST_STATE = '{
        tx_s1: can_wake_pkg::BUS_RECESSIVE,
        tx_s2: can_wake_pkg::BUS_RECESSIVE,
        rx_s1: can_wake_pkg::BUS_RECESSIVE,
        rx_s2: can_wake_pkg::BUS_RECESSIVE,
        dev_prev: can_wake_pkg::DM_NORMAL,
        mode: can_wake_pkg::RESET_MODE,
        wst: W_HOLD,
        wcnt: '0,
        armed: 1'b1,
        woken: 1'b0,
        int_low: 1'b0,
        en_cnt: '0,
        tx_ok: 1'b0,
        drv_en: 1'b0,
        drv_dom: 1'b0,
        rx_out: can_wake_pkg::BUS_RECESSIVE,
        int_n: 1'b1,
        restart: 1'b0,
        pend_v: 1'b0,
        pend: '0
    };

    top_state_s s_reg;
    top_state_s s_next;

    logic buf_in_ready;

    wake_event_buffer #(
        .W($bits(can_wake_pkg::wake_rec_s))
    ) u_wake_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(s_reg.pend_v),
        .in_ready(buf_in_ready),
        .in_data(s_reg.pend),
        .out_valid(wake_valid),
        .out_ready(wake_ready),
        .out_data(wake_rec)
    );

    assign mode_status = s_reg.mode;
    assign restart_req = s_reg.restart;
    assign interrupt_out_n = s_reg.int_n;
    assign bus_rx_output = s_reg.rx_out;
    assign bus_driver_en = s_reg.drv_en;
    assign bus_drive_dominant = s_reg.drv_dom;

    always_comb begin
        logic rx_dom;
        logic tx_dom;
        logic dev_chg;
        logic dev_nrm_stop;
        logic rearm;
        logic det_run;
        logic hit;
        can_wake_pkg::xcvr_mode_e m;

        s_next = s_reg;
        rx_dom = 1'b0;
        tx_dom = 1'b0;
        dev_chg = 1'b0;
        dev_nrm_stop = 1'b0;
        rearm = 1'b0;
        det_run = 1'b0;
        hit = 1'b0;
        m = s_reg.mode;

        // pins pass two flops; only the second is looked at
        s_next.tx_s1 = bus_tx_input;
        s_next.tx_s2 = s_reg.tx_s1;
        s_next.rx_s1 = bus_rx_diff;
        s_next.rx_s2 = s_reg.rx_s1;
        rx_dom = (s_reg.rx_s2 == can_wake_pkg::BUS_DOMINANT);
        tx_dom = (s_reg.tx_s2 == can_wake_pkg::BUS_DOMINANT);

        dev_chg = (dev_mode != s_reg.dev_prev);
        s_next.dev_prev = dev_mode;
        dev_nrm_stop = (dev_mode == can_wake_pkg::DM_NORMAL) ||
                       (dev_mode == can_wake_pkg::DM_STOP);
        s_next.restart = 1'b0;

        // mode commands, all but off gated by the device operating mode
        if (mode_cmd.valid) begin
            case (mode_cmd.mode)
                can_wake_pkg::XM_OFF: begin
                    m = can_wake_pkg::XM_OFF;
                end
                can_wake_pkg::XM_NORMAL, can_wake_pkg::XM_RXONLY: begin
                    if (dev_nrm_stop) begin
                        m = mode_cmd.mode;
                    end
                end
                can_wake_pkg::XM_WAKE: begin
                    if (dev_mode != can_wake_pkg::DM_FAILSAFE) begin
                        m = can_wake_pkg::XM_WAKE;
                    end
                end
                default: begin
                    m = s_reg.mode;
                end
            endcase
        end

        // leaving Normal/Stop drops an active transceiver to wake capable
        if (dev_chg && !dev_nrm_stop &&
            (m == can_wake_pkg::XM_NORMAL ||
             m == can_wake_pkg::XM_RXONLY)) begin
            m = can_wake_pkg::XM_WAKE;
        end
        // fail-safe entry overrides any command in the same cycle
        if (dev_chg && dev_mode == can_wake_pkg::DM_FAILSAFE) begin
            m = can_wake_pkg::XM_WAKE;
        end
        s_next.mode = m;

        // rearm on mode toggle or on entry to a low-power device mode
        if (m != can_wake_pkg::XM_WAKE ||
            s_reg.mode != can_wake_pkg::XM_WAKE) begin
            rearm = 1'b1;
        end
        if (dev_chg && (dev_mode == can_wake_pkg::DM_STOP ||
                        dev_mode == can_wake_pkg::DM_SLEEP ||
                        dev_mode == can_wake_pkg::DM_FAILSAFE)) begin
            rearm = 1'b1;
        end
        if (rearm) begin
            s_next.armed = 1'b1;
            s_next.woken = 1'b0;
            s_next.int_low = 1'b0;
        end

        // a record still waiting on the buffer stalls the detector so
        // no second wake can overwrite it
        det_run = (s_reg.mode == can_wake_pkg::XM_WAKE) && !rearm &&
                  s_reg.armed && !s_reg.pend_v;

        if (!det_run) begin
            s_next.wst = W_HOLD;
            s_next.wcnt = '0;
        end else begin
            case (s_reg.wst)
                W_HOLD: begin
                    // a pattern must open on a fresh dominant edge
                    if (!rx_dom) begin
                        s_next.wst = W_IDLE;
                    end
                end
                W_IDLE: begin
                    if (rx_dom) begin
                        s_next.wst = W_DOM1;
                        s_next.wcnt = CNT_ONE;
                    end
                end
                W_DOM1, W_DOM2: begin
                    if (rx_dom) begin
                        if (s_reg.wcnt >= WMAX) begin
                            s_next.wst = W_HOLD;
                        end else begin
                            s_next.wcnt = s_reg.wcnt + CNT_ONE;
                        end
                    end else if (s_reg.wcnt < WMIN) begin
                        s_next.wst = W_IDLE;
                    end else if (s_reg.wst == W_DOM1) begin
                        s_next.wst = W_REC;
                        s_next.wcnt = CNT_ONE;
                    end else begin
                        s_next.wst = W_IDLE;
                        hit = 1'b1;
                    end
                end
                W_REC: begin
                    if (!rx_dom) begin
                        if (s_reg.wcnt >= WMAX) begin
                            s_next.wst = W_IDLE;
                        end else begin
                            s_next.wcnt = s_reg.wcnt + CNT_ONE;
                        end
                    end else begin
                        // a short gap restarts the pattern on this edge
                        s_next.wst = (s_reg.wcnt > WMIN) ? W_DOM2 : W_DOM1;
                        s_next.wcnt = CNT_ONE;
                    end
                end
                default: begin
                    s_next.wst = W_HOLD;
                end
            endcase
        end

        // hand-off to the buffer; a new hit below wins over the clear
        if (s_reg.pend_v && buf_in_ready) begin
            s_next.pend_v = 1'b0;
        end

        // wake reaction depends on the device mode; mode field untouched
        if (hit) begin
            s_next.armed = 1'b0;
            s_next.woken = 1'b1;
            s_next.int_low = dev_nrm_stop;
            s_next.restart = (dev_mode == can_wake_pkg::DM_SLEEP) ||
                (dev_mode == can_wake_pkg::DM_FAILSAFE);
            s_next.pend_v = 1'b1;
            s_next.pend.dev_mode = dev_mode;
            s_next.pend.int_raised = dev_nrm_stop;
            s_next.pend.restart_raised = s_next.restart;
        end
        s_next.int_n = !s_next.int_low;

        // enable delay restarts on every entry to normal mode
        if (m == can_wake_pkg::XM_NORMAL &&
            s_reg.mode != can_wake_pkg::XM_NORMAL) begin
            s_next.en_cnt = '0;
            s_next.tx_ok = 1'b0;
        end else if (m == can_wake_pkg::XM_NORMAL) begin
            if (s_reg.en_cnt < ENDLY) begin
                s_next.en_cnt = s_reg.en_cnt + CNT_ONE;
            end else if (!tx_dom) begin
                // an early dominant must end before any bit goes out
                s_next.tx_ok = 1'b1;
            end
        end else begin
            s_next.en_cnt = '0;
            s_next.tx_ok = 1'b0;
        end

        // output stages; receive-only keeps the driver off
        s_next.drv_en = (m == can_wake_pkg::XM_NORMAL) &&
                        s_next.tx_ok;
        s_next.drv_dom = s_next.drv_en && tx_dom;

        case (m)
            can_wake_pkg::XM_NORMAL, can_wake_pkg::XM_RXONLY: begin
                s_next.rx_out = s_reg.rx_s2;
            end
            can_wake_pkg::XM_WAKE: begin
                s_next.rx_out = s_next.woken ? can_wake_pkg::BUS_DOMINANT
                                : can_wake_pkg::BUS_RECESSIVE;
            end
            default: begin
                s_next.rx_out = can_wake_pkg::BUS_RECESSIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

// ===== can_mode_wake_assertions.sv
/*
 * port checks for the transceiver mode and wake block.
 * assumes ref_clk alone and the synchronous active-high rst.
 */
`timescale 1ns/1ps
module can_mode_wake_assertions #(
    parameter int WAKE_MIN = 4,
    parameter int WAKE_MAX = 12,
    parameter int EN_DELAY = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // mode control
    input can_wake_pkg::mode_cmd_s mode_cmd,
    input can_wake_pkg::dev_mode_e dev_mode,
    input can_wake_pkg::xcvr_mode_e mode_status,
    input wire logic restart_req,
    input wire logic interrupt_out_n,
    // pins
    input wire logic bus_tx_input,
    input wire logic bus_rx_diff,
    input wire logic bus_rx_output,
    input wire logic bus_driver_en,
    input wire logic bus_drive_dominant,
    // wake records
    input wire logic wake_valid,
    input wire logic wake_ready,
    input can_wake_pkg::wake_rec_s wake_rec
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // one cycle of slack after a mode switch before the outputs settle
    a_off_quiet:
    assert property ($past(mode_status) == can_wake_pkg::XM_OFF
        && mode_status == can_wake_pkg::XM_OFF |-> bus_rx_output
        && interrupt_out_n && !bus_driver_en) else $error("off not quiet");
    a_enable_wait:
    assert property ($rose(mode_status == can_wake_pkg::XM_NORMAL)
        |-> !bus_driver_en [*8]) else $error("driver enabled early");
    a_driver_normal:
    assert property (bus_driver_en |-> mode_status == can_wake_pkg::XM_NORMAL
        || $past(mode_status) == can_wake_pkg::XM_NORMAL)
        else $error("driver on outside normal");
    a_dominant_cause:
    assert property (bus_drive_dominant |-> $past(bus_driver_en)
        && !$past(bus_tx_input, 3)) else $error("dominant without cause");
    a_cmd_refused:
    assert property (mode_cmd.valid && mode_cmd.mode inside
        {can_wake_pkg::XM_NORMAL, can_wake_pkg::XM_RXONLY}
        && !(dev_mode inside {can_wake_pkg::DM_NORMAL, can_wake_pkg::DM_STOP})
        && mode_status != mode_cmd.mode
        |=> mode_status != $past(mode_cmd.mode))
        else $error("mode taken in wrong device mode");
    a_cmd_taken:
    assert property (mode_cmd.valid && mode_cmd.mode inside
        {can_wake_pkg::XM_NORMAL, can_wake_pkg::XM_RXONLY}
        && dev_mode inside {can_wake_pkg::DM_NORMAL, can_wake_pkg::DM_STOP}
        && $stable(dev_mode) |=> mode_status == $past(mode_cmd.mode))
        else $error("mode command lost");
    a_failsafe_force:
    assert property (dev_mode == can_wake_pkg::DM_FAILSAFE
        && $past(dev_mode) != can_wake_pkg::DM_FAILSAFE
        |=> mode_status == can_wake_pkg::XM_WAKE) else $error("no forcing");
    a_wake_held:
    assert property (!bus_rx_output && mode_status == can_wake_pkg::XM_WAKE
        && $past(mode_status) == can_wake_pkg::XM_WAKE && !mode_cmd.valid
        && $stable(dev_mode) |=> !bus_rx_output
        && mode_status == can_wake_pkg::XM_WAKE) else $error("wake not held");
    a_int_cause:
    assert property ($fell(interrupt_out_n) |-> !bus_rx_output
        && $past(dev_mode) inside
        {can_wake_pkg::DM_NORMAL, can_wake_pkg::DM_STOP})
        else $error("interrupt in wrong mode");
    a_restart_pulse:
    assert property (restart_req |-> interrupt_out_n && $past(dev_mode) inside
        {can_wake_pkg::DM_SLEEP, can_wake_pkg::DM_FAILSAFE} ##1 !restart_req)
        else $error("bad restart pulse");
    a_record_held:
    assert property (wake_valid && !wake_ready |=> wake_valid
        && $stable(wake_rec)) else $error("record dropped");
endmodule

bind can_transceiver_mode_wake can_mode_wake_assertions #(
    .WAKE_MIN(WAKE_MIN), .WAKE_MAX(WAKE_MAX), .EN_DELAY(EN_DELAY)
) chk (.ref_clk(ref_clk), .rst(rst), .mode_cmd(mode_cmd),
    .dev_mode(dev_mode), .mode_status(mode_status),
    .restart_req(restart_req), .interrupt_out_n(interrupt_out_n),
    .bus_tx_input(bus_tx_input), .bus_rx_diff(bus_rx_diff),
    .bus_rx_output(bus_rx_output), .bus_driver_en(bus_driver_en),
    .bus_drive_dominant(bus_drive_dominant), .wake_valid(wake_valid),
    .wake_ready(wake_ready), .wake_rec(wake_rec));

// ===== can_host_model.sv
/*
 * host protocol controller model driving the transmit pin.
 * assumes ref_clk; tx_on says the transceiver was put in normal mode.
 */
`timescale 1ns/1ps
module can_host_model #(
    parameter int WAIT = 16
) (
    // clock
    input wire logic ref_clk,
    // control from the bench
    input wire logic tx_on,
    input wire logic early,
    input wire logic want,
    // pin
    output logic tx_pin
);
    int cnt = 0;
    // the host cannot see the enable, so it counts its own margin
    always @(posedge ref_clk) begin
        if (!tx_on) begin
            cnt <= 0;
        end else if (cnt < WAIT) begin
            cnt <= cnt + 1;
        end
    end
    // recessive until the wait is over, unless told to misbehave
    assign tx_pin = (early || cnt >= WAIT) ? want : 1'h1;
endmodule

// ===== tb_can_transceiver_mode_wake.sv
/*
 * self-checking bench for the transceiver mode and wake block.
 * assumes the package, the design, the host model and the checker bind.
 */
`timescale 1ns/1ps
module tb_can_transceiver_mode_wake;
    localparam int EN_DELAY = 10;
    logic ref_clk;
    logic rst;
    can_wake_pkg::mode_cmd_s mode_cmd;
    can_wake_pkg::dev_mode_e dev_mode;
    can_wake_pkg::xcvr_mode_e mode_status;
    logic restart_req;
    logic interrupt_out_n;
    logic bus_tx_input;
    logic bus_rx_diff;
    logic bus_rx_output;
    logic bus_driver_en;
    logic bus_drive_dominant;
    logic wake_valid;
    logic wake_ready;
    can_wake_pkg::wake_rec_s wake_rec;
    logic tx_on;
    logic early;
    logic want;
    int fail_count = 0;
    int tests_run = 0;
    int pulses = 0;

    // short counts keep the run brief
    can_transceiver_mode_wake #(.WAKE_MIN(4), .WAKE_MAX(12),
        .EN_DELAY(EN_DELAY)) DUT (
        .ref_clk(ref_clk),
        .rst(rst),
        .mode_cmd(mode_cmd),
        .dev_mode(dev_mode),
        .mode_status(mode_status),
        .restart_req(restart_req),
        .interrupt_out_n(interrupt_out_n),
        .bus_tx_input(bus_tx_input),
        .bus_rx_diff(bus_rx_diff),
        .bus_rx_output(bus_rx_output),
        .bus_driver_en(bus_driver_en),
        .bus_drive_dominant(bus_drive_dominant),
        .wake_valid(wake_valid),
        .wake_ready(wake_ready),
        .wake_rec(wake_rec)
    );

    can_host_model #(.WAIT(16)) host (
        .ref_clk(ref_clk),
        .tx_on(tx_on),
        .early(early),
        .want(want),
        .tx_pin(bus_tx_input)
    );

    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (restart_req === 1'h1) begin
            pulses++;
        end
    end

    task automatic report_and_stop();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic cmd(input can_wake_pkg::xcvr_mode_e m);
        mode_cmd.valid = 1'h1;
        mode_cmd.mode = m;
        cyc(1);
        mode_cmd.valid = 1'h0;
        cyc(1);
    endtask

    // tail is longer than any legal gap so no phase carries over
    task automatic pattern(input int d1, input int r, input int d2);
        bus_rx_diff = 1'h0;
        cyc(d1);
        bus_rx_diff = 1'h1;
        cyc(r);
        bus_rx_diff = 1'h0;
        cyc(d2);
        bus_rx_diff = 1'h1;
        cyc(20);
    endtask

    task automatic wait_driver();
        int i;
        for (i = 0; i < 60 && bus_driver_en !== 1'h1; i++) begin
            cyc(1);
        end
        chk(i < 60, 1'h1);
        if (i == 60) begin
            report_and_stop();
        end
    endtask

    task automatic take(input logic [7:0] exp);
        chk(wake_valid, 1'h1);
        chk(wake_rec, exp);
        wake_ready = 1'h1;
        cyc(1);
        wake_ready = 1'h0;
        cyc(1);
    endtask

    task automatic t_off();
        chk(mode_status, can_wake_pkg::XM_OFF);
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h1);
        chk(interrupt_out_n, 1'h1);
        chk(wake_valid, 1'h0);
        $display("done t_off");
    endtask

    task automatic t_normal();
        dev_mode = can_wake_pkg::DM_SLEEP;
        cmd(can_wake_pkg::XM_NORMAL);
        chk(mode_status, can_wake_pkg::XM_OFF);
        cmd(can_wake_pkg::XM_RXONLY);
        chk(mode_status, can_wake_pkg::XM_OFF);
        dev_mode = can_wake_pkg::DM_NORMAL;
        cmd(can_wake_pkg::XM_RXONLY);
        chk(mode_status, can_wake_pkg::XM_RXONLY);
        bus_rx_diff = 1'h0;
        cyc(4);
        chk(bus_rx_output, 1'h0);
        chk(bus_driver_en, 1'h0);
        bus_rx_diff = 1'h1;
        early = 1'h1;
        want = 1'h0;
        tx_on = 1'h1;
        cmd(can_wake_pkg::XM_NORMAL);
        chk(mode_status, can_wake_pkg::XM_NORMAL);
        cyc(EN_DELAY + 4);
        chk(bus_driver_en, 1'h0);
        want = 1'h1;
        wait_driver();
        want = 1'h0;
        cyc(4);
        chk(bus_drive_dominant, 1'h1);
        want = 1'h1;
        early = 1'h0;
        tx_on = 1'h0;
        bus_rx_diff = 1'h0;
        cyc(4);
        chk(bus_rx_output, 1'h0);
        bus_rx_diff = 1'h1;
        cmd(can_wake_pkg::XM_OFF);
        want = 1'h0;
        tx_on = 1'h1;
        cmd(can_wake_pkg::XM_NORMAL);
        cyc(20);
        chk(bus_drive_dominant, 1'h1);
        want = 1'h1;
        tx_on = 1'h0;
        $display("done t_normal");
    endtask

    task automatic t_stop_wake();
        dev_mode = can_wake_pkg::DM_STOP;
        cmd(can_wake_pkg::XM_WAKE);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h0);
        chk(interrupt_out_n, 1'h0);
        pattern(8, 8, 8);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        chk(bus_rx_output, 1'h0);
        dev_mode = can_wake_pkg::DM_NORMAL;
        cmd(can_wake_pkg::XM_NORMAL);
        chk(mode_status, can_wake_pkg::XM_NORMAL);
        cmd(can_wake_pkg::XM_WAKE);
        cyc(3);
        chk(bus_rx_output, 1'h1);
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h0);
        chk(interrupt_out_n, 1'h0);
        take({can_wake_pkg::DM_STOP, 1'h1, 1'h0});
        take({can_wake_pkg::DM_NORMAL, 1'h1, 1'h0});
        chk(wake_valid, 1'h0);
        $display("done t_stop_wake");
    endtask

    task automatic t_sleep();
        dev_mode = can_wake_pkg::DM_SLEEP;
        cyc(3);
        chk(bus_rx_output, 1'h1);
        chk(interrupt_out_n, 1'h1);
        cmd(can_wake_pkg::XM_OFF);
        cmd(can_wake_pkg::XM_WAKE);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        pattern(2, 8, 8);
        pattern(8, 16, 8);
        pattern(8, 8, 16);
        chk(bus_rx_output, 1'h1);
        chk(wake_valid, 1'h0);
        pulses = 0;
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h0);
        chk(interrupt_out_n, 1'h1);
        chk(pulses, 1);
        take({can_wake_pkg::DM_SLEEP, 1'h0, 1'h1});
        $display("done t_sleep");
    endtask

    task automatic t_fail();
        dev_mode = can_wake_pkg::DM_RESTART;
        cmd(can_wake_pkg::XM_NORMAL);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        cmd(can_wake_pkg::XM_OFF);
        chk(mode_status, can_wake_pkg::XM_OFF);
        cmd(can_wake_pkg::XM_WAKE);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        pulses = 0;
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h0);
        chk(interrupt_out_n, 1'h1);
        chk(pulses, 0);
        take({can_wake_pkg::DM_RESTART, 1'h0, 1'h0});
        cmd(can_wake_pkg::XM_OFF);
        dev_mode = can_wake_pkg::DM_FAILSAFE;
        cyc(2);
        chk(mode_status, can_wake_pkg::XM_WAKE);
        pulses = 0;
        pattern(8, 8, 8);
        chk(bus_rx_output, 1'h0);
        chk(interrupt_out_n, 1'h1);
        chk(pulses, 1);
        take({can_wake_pkg::DM_FAILSAFE, 1'h0, 1'h1});
        cmd(can_wake_pkg::XM_OFF);
        chk(mode_status, can_wake_pkg::XM_OFF);
        $display("done t_fail");
    endtask

    initial begin
        rst = 1'h1;
        mode_cmd = '0;
        dev_mode = can_wake_pkg::DM_NORMAL;
        bus_rx_diff = 1'h1;
        wake_ready = 1'h0;
        tx_on = 1'h0;
        early = 1'h0;
        want = 1'h1;
        cyc(10);
        rst = 1'h0;
        cyc(1);
        t_off();
        t_normal();
        t_stop_wake();
        t_sleep();
        t_fail();
        report_and_stop();
    end
endmodule
